// File: verilog/flash_self_program_control.sv
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module flash_self_program_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Flash array read port
  output logic [14:0] flash_addr_o,
  output logic flash_space_o,
  output logic flash_read_o,
  input wire logic [13:0] flash_rdata_i,
  // Flash array program and erase
  output logic flash_program_o,
  output logic flash_erase_o,
  output logic [223:0] flash_row_o,
  input wire logic flash_done_i
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] data_low;
    logic [5:0] data_high;
    logic [14:0] addr;
    logic space;
    logic latch_only;
    logic erase;
    logic error;
    logic enable;
    logic write;
    logic read;
    flash_pkg::key_state_e key;
    flash_pkg::op_state_e state;
    logic [15:0][13:0] latch;
  } state_s;

  state_s s;
  state_s next_s;

  // ---------------------------------------------------------------
  // Address map helpers and control byte packing
  // ---------------------------------------------------------------
  function automatic logic cfg_writable(input logic [14:0] a);
    cfg_writable = (a <= flash_pkg::USER_ID_LAST);
  endfunction

  function automatic logic cfg_readable(input logic [14:0] a);
    cfg_readable = (a <= flash_pkg::CFG_LAST) && (a != flash_pkg::CFG_HOLE);
  endfunction

  function automatic logic [7:0] control_byte(input state_s v);
    control_byte = {1'b1, v.space, v.latch_only, v.erase, v.error,
                    v.enable, v.write, v.read};
  endfunction

  logic bus_req;
  logic bus_wr;
  logic mapped;
  logic [2:0] reg_idx;
  logic [7:0] wbyte;
  logic accept;
  logic ctl_wr;

  assign bus_req = cyc_i && stb_i;
  assign reg_idx = adr_i[4:2];
  assign mapped = (adr_i[7:5] == 3'h0) && (adr_i[1:0] == 2'h0) &&
                  (reg_idx <= flash_pkg::REG_UNLOCK_KEY);
  // Writes land on the edge where the master sees ack
  assign bus_wr = bus_req && s.ack && we_i && sel_i[0] && mapped;
  assign wbyte = dat_i[7:0];
  assign ctl_wr = bus_wr && (reg_idx == flash_pkg::REG_CONTROL);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    accept = 1'b0;
    next_s.ack = bus_req && !s.ack;

    // Read data sampled one cycle ahead of ack
    if (bus_req && !s.ack) begin
      next_s.rdata = 32'h0000_0000;
      if (mapped) begin
        unique case (reg_idx)
          flash_pkg::REG_DATA_LOW: next_s.rdata[7:0] = s.data_low;
          flash_pkg::REG_DATA_HIGH: next_s.rdata[7:0] = {2'b00, s.data_high};
          flash_pkg::REG_ADDR_LOW: next_s.rdata[7:0] = s.addr[7:0];
          flash_pkg::REG_ADDR_HIGH: next_s.rdata[7:0] = {1'b1, s.addr[14:8]};
          flash_pkg::REG_CONTROL: next_s.rdata[7:0] = control_byte(s);
          flash_pkg::REG_UNLOCK_KEY: next_s.rdata[7:0] = 8'h00;
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes; operand registers freeze while an operation runs
    if (bus_wr) begin
      if (reg_idx != flash_pkg::REG_UNLOCK_KEY) begin
        next_s.key = flash_pkg::KEY_IDLE;
      end
      unique case (reg_idx)
        flash_pkg::REG_DATA_LOW: begin
          if (s.state == flash_pkg::ST_IDLE) begin
            next_s.data_low = wbyte;
          end
        end
        flash_pkg::REG_DATA_HIGH: begin
          if (s.state == flash_pkg::ST_IDLE) begin
            next_s.data_high = wbyte[5:0];
          end
        end
        flash_pkg::REG_ADDR_LOW: begin
          if (s.state == flash_pkg::ST_IDLE) begin
            next_s.addr[7:0] = wbyte;
          end
        end
        flash_pkg::REG_ADDR_HIGH: begin
          if (s.state == flash_pkg::ST_IDLE) begin
            next_s.addr[14:8] = wbyte[6:0];
          end
        end
        flash_pkg::REG_CONTROL: begin
          if (s.state == flash_pkg::ST_IDLE) begin
            next_s.space = wbyte[flash_pkg::CTL_SPACE];
            next_s.latch_only = wbyte[flash_pkg::CTL_LATCH_ONLY];
            next_s.erase = wbyte[flash_pkg::CTL_ERASE];
            next_s.enable = wbyte[flash_pkg::CTL_ENABLE];
            if (wbyte[flash_pkg::CTL_READ]) begin
              next_s.read = 1'b1;
            end
          end
          next_s.error = wbyte[flash_pkg::CTL_ERROR];
          // Zero in the start bit is simply not acted on
          if (wbyte[flash_pkg::CTL_WRITE]) begin
            next_s.error = 1'b1;
            // Enable, key and address checks gate any start
            accept = (s.state == flash_pkg::ST_IDLE) && next_s.enable &&
                     (s.key == flash_pkg::KEY_ARMED) &&
                     (!next_s.space || cfg_writable(s.addr));
          end
        end
        flash_pkg::REG_UNLOCK_KEY: begin
          if (wbyte == flash_pkg::KEY_FIRST) begin
            next_s.key = flash_pkg::KEY_HALF;
          end else if (wbyte == flash_pkg::KEY_SECOND && s.key == flash_pkg::KEY_HALF) begin
            next_s.key = flash_pkg::KEY_ARMED;
          end else begin
            next_s.key = flash_pkg::KEY_IDLE;
          end
        end
        default: next_s.key = flash_pkg::KEY_IDLE;
      endcase
    end

    // One-cycle read of the addressed word
    if (s.read) begin
      // A fresh software set in the same cycle outlives the hardware clear
      next_s.read = ctl_wr && wbyte[flash_pkg::CTL_READ] &&
                    (s.state == flash_pkg::ST_IDLE);
      if (s.space && !cfg_readable(s.addr)) begin
        next_s.data_low = 8'h00;
        next_s.data_high = 6'h00;
      end else begin
        next_s.data_low = flash_rdata_i[7:0];
        next_s.data_high = flash_rdata_i[13:8];
      end
    end

    // Operation sequencer
    unique case (s.state)
      flash_pkg::ST_IDLE: begin
        if (accept) begin
          next_s.write = 1'b1;
          if (next_s.erase) begin
            next_s.state = flash_pkg::ST_START;
          end else begin
            next_s.latch[s.addr[3:0]] = {s.data_high, s.data_low};
            next_s.state = next_s.latch_only ? flash_pkg::ST_LOAD : flash_pkg::ST_START;
          end
        end
      end
      flash_pkg::ST_LOAD: begin
        next_s.write = 1'b0;
        // A write-start attempt landing now keeps the error flag set
        next_s.error = ctl_wr && next_s.error;
        next_s.state = flash_pkg::ST_IDLE;
      end
      flash_pkg::ST_START: begin
        next_s.state = flash_pkg::ST_BUSY;
      end
      flash_pkg::ST_BUSY: begin
        if (flash_done_i) begin
          next_s.write = 1'b0;
          next_s.error = ctl_wr && next_s.error;
          next_s.erase = 1'b0;
          for (int i = 0; i < flash_pkg::LATCH_WORDS; i++) begin
            next_s.latch[i] = flash_pkg::LATCH_BLANK;
          end
          next_s.state = flash_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.ack <= 1'b0;
      s.rdata <= 32'h0000_0000;
      s.data_low <= flash_pkg::DATA_RESET;
      s.data_high <= flash_pkg::DATA_RESET[5:0];
      s.addr <= flash_pkg::ADDR_RESET;
      s.space <= 1'b0;
      s.latch_only <= 1'b0;
      s.erase <= 1'b0;
      s.error <= 1'b0;
      s.enable <= 1'b0;
      s.write <= 1'b0;
      s.read <= 1'b0;
      s.key <= flash_pkg::KEY_IDLE;
      s.state <= flash_pkg::ST_IDLE;
      s.latch <= {flash_pkg::LATCH_WORDS{flash_pkg::LATCH_BLANK}};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign flash_addr_o = s.addr;
  assign flash_space_o = s.space;
  assign flash_read_o = s.read;
  assign flash_program_o = (s.state == flash_pkg::ST_START) && !s.erase;
  assign flash_erase_o = (s.state == flash_pkg::ST_START) && s.erase;
  assign flash_row_o = s.latch;

endmodule

// File: verilog/flash_pkg.sv
package flash_pkg;
  // ---------------------------------------------------------------
  // Register word indices and byte offsets on the Wishbone slave
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_DATA_LOW = 3'h0;
  localparam logic [2:0] REG_DATA_HIGH = 3'h1;
  localparam logic [2:0] REG_ADDR_LOW = 3'h2;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
  localparam logic [2:0] REG_CONTROL = 3'h4;
  localparam logic [2:0] REG_UNLOCK_KEY = 3'h5;
  localparam int OFFSET_DATA_LOW = 32'h0000_0000;
  localparam int OFFSET_UNLOCK_KEY = 32'h0000_0014;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_SPACE = 6;
  localparam int CTL_LATCH_ONLY = 5;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ERROR = 3;
  localparam int CTL_ENABLE = 2;
  localparam int CTL_WRITE = 1;
  localparam int CTL_READ = 0;

  // ---------------------------------------------------------------
  // Reset values, keys, geometry
  // ---------------------------------------------------------------
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [13:0] LATCH_BLANK = 14'h3FFF;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int LATCH_WORDS = 16;
  localparam int WORD_BITS = 14;
  localparam logic [14:0] USER_ID_LAST = 15'h0003;
  localparam logic [14:0] CFG_HOLE = 15'h0004;
  localparam logic [14:0] CFG_LAST = 15'h0008;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_START = 4'b0100,
    ST_BUSY = 4'b1000
  } op_state_e;
endpackage

// File: tb/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
  // Clock
  input wire logic clk_i,
  // Array requests
  input wire logic [14:0] addr_i,
  input wire logic space_i,
  input wire logic read_i,
  input wire logic start_i,
  input wire logic [3:0] delay_i,
  // Array answers
  output logic [13:0] rdata_o,
  output logic done_o
);
  logic [3:0] count = 4'h0;
  logic [13:0] word;
  assign word = {space_i, addr_i[12:0]} ^ 14'h2A5C;
  // Inverse outside a read, so a late sample never matches
  assign rdata_o = read_i ? word : ~word;
  always_ff @(posedge clk_i) begin
    done_o <= start_i ? 1'b0 : (count == 4'h1);
    if (start_i) begin
      count <= delay_i;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end
endmodule

// File: tb/flash_self_program_control_sva.sv
`timescale 1ns/1ps
module flash_self_program_control_sva (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i, stb_i, we_i, ack_o,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i, dat_o,
  // Array side
  input wire logic [14:0] flash_addr_o,
  input wire logic flash_space_o, flash_read_o, flash_program_o, flash_erase_o, flash_done_i,
  input wire logic [13:0] flash_rdata_i,
  input wire logic [223:0] flash_row_o
);
  logic busy;
  always_ff @(posedge clk_i) begin
    if (rst_i || flash_done_i) begin
      busy <= 1'b0;
    end else if (flash_program_o || flash_erase_o) begin
      busy <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_s(logic [7:0] a);
    req_s ##0 (!we_i && adr_i == a);
  endsequence
  ack_next_a: assert property (req_s |=> ack_o) else $error("request not acked");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  data_high_a: assert property (rd_s(8'h04) |=> dat_o[31:6] == 26'h0)
    else $error("data high top bits set");
  addr_high_a: assert property (rd_s(8'h0C) |=> dat_o[31:7] == 25'h1)
    else $error("address high bit 7 not one");
  ctl_top_a: assert property (rd_s(8'h10) |=> dat_o[7]) else $error("control bit 7 low");
  key_hidden_a: assert property (rd_s(8'h14) |=> dat_o == 32'h0)
    else $error("key readable");
  read_start_a: assert property (req_s ##0 (we_i && adr_i == 8'h10 && sel_i[0] && dat_i[0] && !busy)
    |-> ##2 flash_read_o ##1 !flash_read_o) else $error("read strobe wrong");
  one_op_a: assert property (!(flash_program_o && flash_erase_o))
    else $error("program and erase together");
  busy_hold_a: assert property (busy |-> !flash_program_o && !flash_erase_o)
    else $error("start while busy");
  blank_done_a: assert property (busy && flash_done_i |=> flash_row_o == {16{14'h3FFF}})
    else $error("latches not blank after done");
endmodule
bind flash_self_program_control flash_self_program_control_sva sva (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .ack_o, .adr_i, .sel_i, .dat_i, .dat_o, .flash_addr_o, .flash_space_o,
  .flash_read_o, .flash_program_o, .flash_erase_o, .flash_done_i, .flash_rdata_i, .flash_row_o);

// File: tb/flash_self_program_control_tb.sv
`timescale 1ns/1ps
module flash_self_program_control_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, v;
  logic [3:0] sel_i = 4'h0, delay = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, flash_space_o, flash_read_o, flash_program_o, flash_erase_o, flash_done_i;
  logic [14:0] flash_addr_o, a, pa = 15'h0000;
  logic [13:0] flash_rdata_i, d;
  logic [223:0] flash_row_o;
  logic [13:0] lat[16];
  int failures = 0, tests_run = 0, cycles = 0, progs = 0, erases = 0;
  int rv[7] = '{0, 0, 0, 32'h80, 32'h80, 0, 0};
  always #25 clk_i = ~clk_i;
  flash_self_program_control dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .flash_addr_o, .flash_space_o, .flash_read_o, .flash_rdata_i,
    .flash_program_o, .flash_erase_o, .flash_row_o, .flash_done_i);
  flash_array_model array (.clk_i, .addr_i(flash_addr_o), .space_i(flash_space_o),
    .read_i(flash_read_o), .start_i(flash_program_o || flash_erase_o), .delay_i(delay),
    .rdata_o(flash_rdata_i), .done_o(flash_done_i));
  // ----
  // Bus and checking
  // ----
  always @(posedge clk_i) begin
    progs += (flash_program_o === 1'b1);
    erases += (flash_erase_o === 1'b1);
    if (flash_program_o === 1'b1 || flash_erase_o === 1'b1) pa = flash_addr_o;
    if (cycles++ > 4000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [223:0] seen, input logic [223:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, wr, ad, 4'h1};
    dat_i <= {24'h0, wd};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rg(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 8'h00);
    chk(rd, e);
  endtask
  task automatic fetch(input logic s, input logic [14:0] ad, input logic [13:0] e);
    bus(1'b1, 8'h08, ad[7:0]);
    bus(1'b1, 8'h0C, {1'b0, ad[14:8]});
    bus(1'b1, 8'h10, {1'b0, s, 6'h01});
    rg(8'h00, {24'h0, e[7:0]});
    rg(8'h04, {26'h0, e[13:8]});
    rg(8'h10, {24'h0, 1'b1, s, 6'h00});
  endtask
  task automatic start(input logic [7:0] ad, input logic [13:0] wd, input logic [7:0] c);
    bus(1'b1, 8'h08, ad);
    bus(1'b1, 8'h00, wd[7:0]);
    bus(1'b1, 8'h04, {2'b00, wd[13:8]});
    bus(1'b1, 8'h14, 8'h55);
    bus(1'b1, 8'h14, 8'hAA);
    bus(1'b1, 8'h10, c);
  endtask
  function automatic logic [223:0] row_of();
    logic [223:0] r;
    foreach (lat[i]) r[14*i +: 14] = lat[i];
    return r;
  endfunction
  task automatic settle();
    do bus(1'b0, 8'h10, 8'h00); while (rd[1] !== 1'b0);
  endtask
  task automatic results();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    rd = $urandom(32'h32312980);
    foreach (lat[i]) lat[i] = 14'h3FFF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rv[i]) rg(8'(i * 4), rv[i]);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      bus(1'b1, 8'(i * 4), v);
      rg(8'(i * 4), i == 1 ? v & 8'h3F : i == 3 ? v | 8'h80 : v);
    end
    $display("register access done");
    a = 15'($urandom);
    fetch(1'b0, a, {1'b0, a[12:0]} ^ 14'h2A5C);
    for (int k = 0; k < 10; k++) begin
      a = k == 9 ? 15'h0020 : 15'(k);
      fetch(1'b1, a, (k == 4 || k == 9) ? 14'h0 : {1'b1, a[12:0]} ^ 14'h2A5C);
    end
    $display("reads done");
    bus(1'b1, 8'h10, 8'h06);
    rg(8'h10, 32'h8C);
    start(8'h00, 14'h1234, 8'h02);
    rg(8'h10, 32'h88);
    bus(1'b1, 8'h14, 8'h55);
    bus(1'b1, 8'h00, 8'h11);
    bus(1'b1, 8'h14, 8'hAA);
    bus(1'b1, 8'h10, 8'h26);
    rg(8'h10, 32'hAC);
    chk(flash_row_o, row_of());
    chk(progs + erases, 0);
    $display("refused starts done");
    for (int i = 0; i < 3; i++) begin
      d = 14'($urandom);
      start(8'(i * 5), d, 8'h26);
      lat[i * 5] = d;
    end
    rg(8'h10, 32'hA4);
    chk(flash_row_o, row_of());
    delay <= 4'h8;
    start(8'h0F, 14'h2BCD, 8'h06);
    rg(8'h10, 32'h8E);
    bus(1'b1, 8'h10, 8'h08);
    rg(8'h10, 32'h8E);
    settle();
    foreach (lat[i]) lat[i] = 14'h3FFF;
    chk({progs, erases}, {32'h1, 32'h0});
    chk(pa, 15'h000F);
    chk(flash_row_o, row_of());
    rg(8'h10, 32'h84);
    $display("program done");
    delay <= 4'h1;
    start(8'h12, 14'h0F0F, 8'h36);
    settle();
    chk({progs, erases}, {32'h1, 32'h1});
    chk(pa, 15'h0012);
    chk(flash_row_o, row_of());
    rg(8'h10, 32'hA4);
    $display("erase done");
    start(8'h05, 14'h1111, 8'h46);
    rg(8'h10, 32'hCC);
    chk(progs + erases, 2);
    d = 14'($urandom);
    start(8'h02, d, 8'h66);
    lat[2] = d;
    rg(8'h10, 32'hE4);
    chk(flash_row_o, row_of());
    $display("config space done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (lat[i]) lat[i] = 14'h3FFF;
    rg(8'h08, 32'h0);
    rg(8'h0C, 32'h80);
    rg(8'h10, 32'h80);
    chk(flash_row_o, row_of());
    $display("second reset done");
    results();
  end
endmodule
